/* watchdog_timer_unit.v */
/*
  Watchdog timer unit: control register, mode decode, clear logic,
  prescaled interval counter and time-out handling (reset or wake).
  Assumes the low-frequency oscillator arrives as a one-cycle tick enable
  synchronous to mclk_i, and that the core, sleep controller and reset
  logic are synchronous to mclk_i as well.

*/
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "wdt_defines.vh"

module watchdog_timer_unit #(
  parameter CNT_W = 24                          // Width of full prescale chain
) (
  input  wire                   mclk_i,             // System clock, 250 MHz
  input  wire                   rst_i,              // Asynchronous reset, active high
  input  wire [`WDT_ADDR_W-1:0] addr_i,             // Register address
  input  wire [7:0]             wdata_i,            // Register write data
  input  wire                   wr_i,               // Write strobe
  input  wire                   rd_i,               // Read strobe
  output reg  [7:0]             rdata_o,            // Read data, cycle after read
  input  wire [1:0]             wdt_mode_cfg_i,     // Mode configuration field
  input  wire                   low_freq_int_osc_i, // Oscillator tick enable
  input  wire                   wdt_clear_instr_i,  // Clear-watchdog executed
  input  wire                   sleep_i,            // Device is in Sleep
  input  wire                   osc_fail_i,         // Oscillator failure seen
  input  wire                   crystal_clk_i,      // System clock is crystal type
  input  wire                   osc_startup_timer_i,// Start-up timer running
  input  wire [3:0]             int_osc_divider_sel_i, // Divider select, not used
  input  wire                   status_clr_i,       // Core sets both status flags
  output reg                    wdt_reset_o,        // Device reset request pulse
  output reg                    wake_o,             // Wake request pulse
  output reg                    timeout_flag_n_o,   // Low after a time-out
  output reg                    powerdown_flag_n_o  // Low after a sleep time-out
);

  reg  [4:0]       wdt_period_sel_q;     // Period select field
  reg              sw_wdt_enable_q;      // Software enable
  reg              sleep_q;              // Sleep seen last cycle
  reg              run_q;                // Watchdog active last cycle
  reg              timeout_q;            // Time-out hit, one cycle
  reg              run_d;                // Active now
  reg  [4:0]       ps_eff;               // Effective period code
  reg              clear;                // Any clear condition
  wire [CNT_W-1:0] count;                // Prescale chain count
  wire             hit;                  // Selected bit about to carry

  // Register writes; the divider select input never reaches the count
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wdt_period_sel_q <= `WDT_PS_RESET;
      sw_wdt_enable_q  <= 1'b0;
    end
    else if (wr_i && addr_i == `WDT_CTRL_ADDR)
    begin
      wdt_period_sel_q <= wdata_i[`WDT_PS_MSB:`WDT_PS_LSB];
      sw_wdt_enable_q  <= wdata_i[`WDT_EN_BIT];
    end
  end

  // Mode decode against sleep state
  always @*
  begin
    case (wdt_mode_cfg_i)
      `WDT_MODE_ON:    run_d = 1'b1;
      `WDT_MODE_NOSLP: run_d = ~sleep_i;
      `WDT_MODE_SW:    run_d = sw_wdt_enable_q;
      default:         run_d = 1'b0;
    endcase
  end

  // Reserved codes fold back to the minimum interval
  always @*
  begin
    if (wdt_period_sel_q > `WDT_PS_MAX)
      ps_eff = 5'h00;
    else
      ps_eff = wdt_period_sel_q;
  end

  // Clear sources; sleep edges in both directions, start-up hold on crystal
  always @*
  begin
    clear = wdt_clear_instr_i | osc_fail_i | ~run_d
          | (sleep_i ^ sleep_q)
          | (~sleep_i & crystal_clk_i & osc_startup_timer_i)
          | timeout_q;
  end

  // One chain: the low 5 bits are the 1:32 prescaler, so a clear zeroes
  // prescaler and interval together
  wdt_tick_counter #(
    .WIDTH   (CNT_W)
  ) u_chain (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .clr_i   (clear),
    .inc_i   (low_freq_int_osc_i),
    .count_o (count)
  );

  // Ratio 2^(code+5): time-out when the low code+5 bits are all ones
  // and one more tick arrives
  assign hit = low_freq_int_osc_i & ~clear &
               (&(count | ~((({{(CNT_W-1){1'b0}}, 1'b1}) << (ps_eff + 5'd5))
                            - {{(CNT_W-1){1'b0}}, 1'b1})));

  // Time-out outcome and status flags; the event beats a core update
  // A time-out in the same cycle as a core clear must win, otherwise
  // software could erase the only record of the event it must see
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sleep_q            <= 1'b0;
      run_q              <= 1'b0;
      timeout_q          <= 1'b0;
      wdt_reset_o        <= 1'b0;
      wake_o             <= 1'b0;
      timeout_flag_n_o   <= 1'b1;
      powerdown_flag_n_o <= 1'b1;
    end
    else
    begin
      sleep_q     <= sleep_i;
      run_q       <= run_d;
      timeout_q   <= hit;
      wdt_reset_o <= hit & ~sleep_i;
      wake_o      <= hit & sleep_i;
      if (hit)
      begin
        timeout_flag_n_o   <= 1'b0;
        powerdown_flag_n_o <= ~sleep_i;
      end
      else if (status_clr_i)
      begin
        timeout_flag_n_o   <= 1'b1;
        powerdown_flag_n_o <= 1'b1;
      end
    end
  end

  // Read port; unmapped addresses read zero, bits 7-6 read zero
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      case (addr_i)
        `WDT_CTRL_ADDR: rdata_o <= {2'b00, wdt_period_sel_q, sw_wdt_enable_q};
        `WDT_STAT_ADDR: rdata_o <= {4'h0, run_q, sleep_q,
                                    powerdown_flag_n_o, timeout_flag_n_o};
        default:        rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

endmodule // watchdog_timer_unit

/* wdt_defines.vh */
/*
  Constants for the watchdog timer unit: register offsets, field positions,
  reset values, mode codes and time base figures.
  Assumes it is included by its bare name from the design files.
*/
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// Register map (byte offsets on the plain register port)
`define WDT_ADDR_W          4
`define WDT_CTRL_ADDR       4'h0
`define WDT_STAT_ADDR       4'h4

// Control register fields
`define WDT_EN_BIT          0
`define WDT_PS_LSB          1
`define WDT_PS_MSB          5
`define WDT_PS_RESET        5'h0B
`define WDT_PS_MAX          5'h12

// Status register fields
`define WDT_STAT_TO_BIT     0
`define WDT_STAT_PD_BIT     1
`define WDT_STAT_SLP_BIT    2
`define WDT_STAT_RUN_BIT    3

// Mode configuration codes
`define WDT_MODE_OFF        2'h0
`define WDT_MODE_SW         2'h1
`define WDT_MODE_NOSLP      2'h2
`define WDT_MODE_ON         2'h3

// Time base: prescaler of 32 low-frequency ticks is the 1 ms base period
`define WDT_BASE_RATIO      32
`define WDT_LF_KHZ          31
`define WDT_BASE_MS         1

`endif

/* wdt_tick_counter.v */
/*
  Resettable binary counter advanced by a one-cycle enable.
  Assumes one clock domain; clear has priority over counting.
*/
`timescale 1ns/1ps

module wdt_tick_counter #(
  parameter WIDTH = 24                  // Counter width
) (
  input  wire             mclk_i,       // System clock
  input  wire             rst_i,        // Asynchronous reset, active high
  input  wire             clr_i,        // Synchronous clear
  input  wire             inc_i,        // Count enable pulse
  output wire [WIDTH-1:0] count_o       // Current count
);

  reg [WIDTH-1:0] count_q;              // Count register

  // Clear wins over increment so a clear never leaves a stale count
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      count_q <= {WIDTH{1'b0}};
    else if (clr_i)
      count_q <= {WIDTH{1'b0}};
    else if (inc_i)
      count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  assign count_o = count_q;

endmodule // wdt_tick_counter

/* wdt_properties.sv */
/* Port assertions for the watchdog timer unit.
   Assumes one clock domain and an active-high reset. */
`timescale 1ns/1ps
module wdt_properties (
  input wire       mclk_i,
  input wire       rst_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire [1:0] wdt_mode_cfg_i,
  input wire       wdt_clear_instr_i,
  input wire       sleep_i,
  input wire       status_clr_i,
  input wire       wdt_reset_o,
  input wire       wake_o,
  input wire       timeout_flag_n_o,
  input wire       powerdown_flag_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Any time-out event
  wire ev = wdt_reset_o | wake_o;
  // A clear leaves no room for a time-out for many cycles
  sequence quiet_s; !ev [*8]; endsequence
  sequence flag_clr_s; status_clr_i ##1 !ev; endsequence
  awake_reset_a:
    assert property (wdt_reset_o |-> !$past(sleep_i)) else $error("reset in sleep");
  sleep_wake_a:
    assert property (wake_o |-> $past(sleep_i)) else $error("wake while awake");
  wake_flags_a:
    assert property (wake_o |-> !timeout_flag_n_o && !powerdown_flag_n_o) else $error("flags");
  reset_flag_a:
    assert property (wdt_reset_o |-> !timeout_flag_n_o) else $error("timeout flag");
  clear_quiet_a:
    assert property (wdt_clear_instr_i |-> ##1 quiet_s) else $error("event after clear");
  mode_off_a:
    assert property (wdt_mode_cfg_i == 2'h0 |-> ##2 !ev) else $error("event when off");
  sleep_off_a:
    assert property (wdt_mode_cfg_i == 2'h2 && sleep_i |-> ##2 !ev) else $error("sleep event");
  read_idle_a:
    assert property (!rd_i |=> rdata_o == 8'h00) else $error("idle read data");
  read_top_a:
    assert property (rd_i |=> rdata_o[7:6] == 2'h0) else $error("top bits set");
  flag_restore_a:
    assert property (flag_clr_s |-> timeout_flag_n_o && powerdown_flag_n_o) else $error("flags");
endmodule // wdt_properties

/* wdt_core_model.sv */
/* Core-side model: oscillator ticks and the sleep controller.
   Assumes the watchdog clock; a wake pulse ends sleep. */
`timescale 1ns/1ps
module wdt_core_model (
  input  wire mclk_i,
  input  wire rst_i,
  input  wire sleep_req_i, // Bench asks for sleep
  input  wire wake_i,      // Wake pulse from watchdog
  output reg  tick_o,      // Tick every fourth cycle
  output reg  sleep_o      // Device asleep
);
  reg [1:0] div_q; // Tick divider, free running like the oscillator
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_q   <= 2'h0;
      tick_o  <= 1'b0;
      sleep_o <= 1'b0;
    end
    else
    begin
      div_q   <= div_q + 2'h1;
      tick_o  <= (div_q == 2'h3);
      sleep_o <= wake_i ? 1'b0 : sleep_req_i;
    end
  end
endmodule // wdt_core_model

/* tb_watchdog_timer_unit.sv */
/* Self-checking bench: registers, modes, time-outs, sleep wake.
   Assumes the core model supplies ticks and sleep state. */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_watchdog_timer_unit;
  reg        mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, clr_i = 0, sreq = 0, sclr = 0, rd_q = 0;
  reg  [3:0] addr_i = 0, dsel = 0;
  reg  [7:0] wdata_i = 0, w, exp_r;
  reg        ofail = 0, xtal = 0, osc_startup_timer = 0; // Oscillator fail, crystal, start-up timer
  reg  [1:0] mode = 0;
  wire [7:0] rdata_o;
  wire       tick, slp, wrst, wake, to_n, pd_n;
  integer    errors = 0, checks = 0, n, t;
  reg  [7:0] expq[$]; // Expected read data, oldest first
  watchdog_timer_unit watchdog_timer_unit_inst (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wdt_mode_cfg_i(mode),
    .low_freq_int_osc_i(tick), .wdt_clear_instr_i(clr_i), .sleep_i(slp), .osc_fail_i(ofail),
    .crystal_clk_i(xtal), .osc_startup_timer_i(osc_startup_timer), .int_osc_divider_sel_i(dsel),
    .status_clr_i(sclr), .wdt_reset_o(wrst), .wake_o(wake), .timeout_flag_n_o(to_n),
    .powerdown_flag_n_o(pd_n));
  wdt_core_model wdt_core_model_inst (.mclk_i(mclk_i), .rst_i(rst_i), .sleep_req_i(sreq),
    .wake_i(wake), .tick_o(tick), .sleep_o(slp));
  initial forever #2 mclk_i = ~mclk_i;
  // Read data stand only in the cycle after the strobe
  always @(posedge mclk_i)
  begin
    if (rd_q)
    begin
      exp_r = expq.pop_front();
      `CHK(rdata_o, exp_r)
    end
    rd_q <= rd_i;
  end
  task wr(input [3:0] a, input [7:0] d);
    begin @(posedge mclk_i); addr_i <= a; wdata_i <= d; wr_i <= 1; @(posedge mclk_i); wr_i <= 0; end
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin @(posedge mclk_i); addr_i <= a; rd_i <= 1; expq.push_back(e); @(posedge mclk_i); rd_i <= 0; end
  endtask
  // Clear, then count ticks up to the event; r of zero means none due
  task tout(input [4:0] c, input [1:0] m, input en, input s, input [7:0] r);
    begin
      mode <= m; sreq <= s; wr(4'h0, {2'h0, c, en}); repeat (4) @(posedge mclk_i);
      clr_i <= 1; @(posedge mclk_i); clr_i <= 0; n = 0;
      // Divider select wanders meanwhile and must not matter
      for (t = 0; t < 600 && !(wrst || wake); t++) begin dsel <= 4'($urandom); @(posedge mclk_i); n += tick; end
      `CHK({wrst, wake}, r == 0 ? 2'b00 : {!s, s}) // Event kind
      if (r != 0) `CHK(n, r) // Ticks per period
      sreq <= 0; repeat (4) @(posedge mclk_i); $display("test mode %h code %h done", m, c);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin #80000; errors++; close_out; end
  initial
  begin
    n = $urandom(56125);
    repeat (12) @(posedge mclk_i); rst_i <= 0;
    rd(4'h0, 8'h16);
    repeat (3) begin w = $urandom; wr(4'h0, w); rd(4'h0, {2'h0, w[5:0]}); end
    rd(4'h8, 8'h00); $display("registers done");
    tout(5'h00, 2'h3, 0, 0, 32);
    tout(5'h01, 2'h1, 1, 0, 64);
    tout(5'h13, 2'h2, 0, 0, 32);
    tout(5'h1F, 2'h3, 0, 1, 32);
    `CHK({to_n, pd_n}, 2'b00)
    @(posedge mclk_i); sclr <= 1; @(posedge mclk_i); sclr <= 0; @(posedge mclk_i);
    `CHK({to_n, pd_n}, 2'b11)
    rd(4'h4, 8'h0B); // Status: running, awake, flags set
    tout(5'h00, 2'h2, 1, 1, 0);
    tout(5'h00, 2'h1, 0, 0, 0);
    tout(5'h00, 2'h0, 1, 0, 0);
    tout(5'h00, 2'h1, 1, 1, 32);
    // Held clear by the start-up timer and by an oscillator failure
    mode <= 2'h3; xtal <= 1; osc_startup_timer <= 1; n = 0;
    repeat (300) begin @(posedge mclk_i); n += wrst; end
    `CHK(n, 0)
    osc_startup_timer <= 0; xtal <= 0; ofail <= 1; n = 0;
    repeat (300) begin @(posedge mclk_i); n += wrst; end
    `CHK(n, 0)
    ofail <= 0; $display("hold tests done");
    rst_i <= 1; @(posedge mclk_i); rst_i <= 0;
    rd(4'h0, 8'h16);
    repeat (2) @(posedge mclk_i);
    close_out;
  end
endmodule // tb_watchdog_timer_unit
bind watchdog_timer_unit wdt_properties wdt_properties_inst (.mclk_i(mclk_i), .rst_i(rst_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .wdt_mode_cfg_i(wdt_mode_cfg_i), .sleep_i(sleep_i),
  .wdt_clear_instr_i(wdt_clear_instr_i), .status_clr_i(status_clr_i), .wake_o(wake_o),
  .wdt_reset_o(wdt_reset_o), .timeout_flag_n_o(timeout_flag_n_o),
  .powerdown_flag_n_o(powerdown_flag_n_o));
